// >>> design/psdf_pkg.sv
// Shared constants and types of the pitch speed data formatter.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
package psdf_pkg;
	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] PSDF_CTRL_OFS   = 8'h00;
	localparam logic [7:0] PSDF_SPEED_OFS  = 8'h04;
	localparam logic [7:0] PSDF_BLANK_OFS  = 8'h08;
	localparam logic [7:0] PSDF_CYCLE_OFS  = 8'h0c;
	localparam logic [7:0] PSDF_KEY_OFS    = 8'h10;
	localparam logic [7:0] PSDF_RADAR_OFS  = 8'h14;
	localparam logic [7:0] PSDF_STATUS_OFS = 8'h18;
	localparam logic [7:0] PSDF_LABEL_OFS  = 8'h20;
	localparam logic [7:0] PSDF_CODE_RST   = 8'hbf;
	localparam logic [7:0] PSDF_BLANK_RST  = 8'h00;
	localparam logic [7:0] PSDF_CYCLE_RST  = 8'h02;
	// ==========================================================
	// Sport codes
	localparam logic [7:0] PSDF_CODE_MAN_A  = 8'hbf;
	localparam logic [7:0] PSDF_CODE_AUTO_A = 8'hc0;
	localparam logic [7:0] PSDF_CODE_MAN_B  = 8'hc1;
	localparam logic [7:0] PSDF_CODE_AUTO_B = 8'hc2;
	// ==========================================================
	// Key commands, KEY register bits [3:0]; pitch frame in [12:8]
	typedef enum logic [3:0] {
		PSDF_KEY_PITCH     = 4'h1,
		PSDF_KEY_SPEED     = 4'h2,
		PSDF_KEY_BLANK     = 4'h3,
		PSDF_KEY_FIX_IMP   = 4'h4,
		PSDF_KEY_FIX_MET   = 4'h5,
		PSDF_KEY_ALT_IMP   = 4'h6,
		PSDF_KEY_ALT_MET   = 4'h7
	} psdf_key_t;
	// ==========================================================
	// Frame layout
	localparam logic [4:0] PSDF_FRAME_BLANK = 5'h0a;
	localparam logic [4:0] PSDF_FRAME_MAX   = 5'h12;
	localparam logic [7:0] PSDF_STX         = 8'h02;
	localparam logic [7:0] PSDF_ETX         = 8'h03;
	localparam logic [7:0] PSDF_SPACE       = 8'h20;
	localparam logic [7:0] PSDF_ZERO        = 8'h30;
	localparam logic [4:0] PSDF_LAST_IDX    = 5'h18;
	localparam logic [4:0] PSDF_LABEL_IDX   = 5'h05;
	localparam logic [4:0] PSDF_KPH_IDX     = 5'h15;
	localparam logic [9:0] PSDF_KPH_MUL     = 10'h19c;
	localparam logic [9:0] PSDF_SPEED_MAX   = 10'h3e7;
	// ==========================================================
	// Timing
	localparam int PSDF_CLK_HZ   = 250_000_000;
	localparam int PSDF_BAUD     = 1200;
	localparam int PSDF_BIT_CYC  = PSDF_CLK_HZ / PSDF_BAUD;
	localparam int PSDF_SEC_CYC  = PSDF_CLK_HZ;
	localparam int PSDF_FIFO_DEP = 16;
	// ==========================================================
	typedef enum logic [1:0] {FR_IDLE = 2'b01, FR_SEND = 2'b10} psdf_fr_t;
	typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_BUSY = 2'b10} psdf_tx_t;
	typedef struct packed {
		logic [4:0] frame;
		logic [9:0] mph;
		logic [9:0] kph;
		logic       shown;
		logic       metric;
		logic       matrix;
	} psdf_snap_t;
endpackage

// >>> design/psdf_formatter.sv
// Pitch speed formatter: AXI4-Lite registers, frame builder, FIFO, serial sender.
// Assumes the display controller listens on TXD at the configured baud rate.
// What this block does
// - Code 191 manual: pitch key sends; code 192 auto: radar speed sends at once.
// - Codes 193 manual and 194 automatic serve the alternate radar gun.
// - Matrix display gets speed and pitch label; fixed-digit display gets speed only.
// - Any pitch key sends the pitch type and current speed as live items.
// - Speed-only key sends the speed with the blank frame.
// - Blank key clears the speed and sends the blank frame.
// - Settable blank timeout removes speed and label; zero disables it.
// - Operator may overwrite the stored speed.
// - Fix keys select imperial or metric and stop alternation.
// - Alternate keys toggle units at the cycle rate, in either start order.
// - Alternation period is a settable count of whole seconds.
// - Items 1 to 3 hold imperial hundreds, tens and units.
// - Items 4 to 19 hold the sixteen label characters.
// - Items 20 to 22 hold metric hundreds, tens and units.
// - Frame number 1 to 18 encodes the pitch type; 10 is blank.
// - Serial link runs at 1200 baud, eight data bits, no parity.
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ns
module psdf_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output      logic         in_ready,
	output      logic [W-1:0] out_data,
	output      logic         out_valid,
	input  wire logic         out_ready
);
	localparam int A = $clog2(D);
	logic [W-1:0] mem [D];
	logic [A:0]   wp_r;
	logic [A:0]   rp_r;
	logic         push;
	logic         pop;
	assign in_ready  = (wp_r - rp_r) != (A+1)'(D);
	assign out_valid = wp_r != rp_r;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rp_r[A-1:0]];
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r[A-1:0]] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_r + (A+1)'(push);
			rp_r <= rp_r + (A+1)'(pop);
		end
	end
endmodule

module psdf_formatter
	import psdf_pkg::*;
#(
	parameter int BIT_CYC = PSDF_BIT_CYC,
	parameter int SEC_CYC = PSDF_SEC_CYC
) (
	input  wire logic        CLK,
	input  wire logic        NRST,
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output      logic        AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output      logic        WREADY,
	output      logic [1:0]  BRESP,
	output      logic        BVALID,
	input  wire logic        BREADY,
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output      logic        ARREADY,
	output      logic [31:0] RDATA,
	output      logic [1:0]  RRESP,
	output      logic        RVALID,
	input  wire logic        RREADY,
	output      logic        TXD
);
	// ==========================================================
	// Register bus
	logic [7:0]  aw_r, ar_addr;
	logic [31:0] w_r, wd;
	logic [3:0]  ws_r;
	logic        awf_r, wf_r, bv_r, rv_r, wr_go, rd_go, bad_w;
	logic [1:0]  bresp_r, rresp_r;
	logic [31:0] rdata_r, rd_val;
	logic [7:0]  code_r, blank_t_r, cycle_t_r;
	logic        matrix_r;
	logic [31:0] label_r [4];
	logic [9:0]  mph_r, kph;
	logic [4:0]  frame_r;
	logic        shown_r, metric_r, alt_r, pend_r, trig;
	logic        auto_md, alt_gun, k_go, r_go, blank_fire, cyc_fire;
	psdf_fr_t    fr_r;
	psdf_tx_t    tx_r;
	logic [4:0]  idx_r;
	psdf_snap_t  snap_r;
	logic [19:0] kph_full;
	assign AWREADY = !awf_r;
	assign WREADY  = !wf_r;
	assign BVALID  = bv_r;
	assign BRESP   = bresp_r;
	assign ARREADY = !rv_r;
	assign RVALID  = rv_r;
	assign RDATA   = rdata_r;
	assign RRESP   = rresp_r;
	assign wr_go   = awf_r & wf_r & !bv_r;
	assign rd_go   = ARVALID & !rv_r;
	assign ar_addr = ARADDR;
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wd[8*b+:8] = ws_r[b] ? w_r[8*b+:8] : 8'h00;
		end
	end
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			awf_r   <= 1'b0;
			wf_r    <= 1'b0;
			aw_r    <= 8'h00;
			w_r     <= 32'h0;
			ws_r    <= 4'h0;
			bv_r    <= 1'b0;
			bresp_r <= 2'h0;
		end else begin
			if (AWVALID && !awf_r) begin
				awf_r <= 1'b1;
				aw_r  <= AWADDR;
			end else if (wr_go) begin
				awf_r <= 1'b0;
			end
			if (WVALID && !wf_r) begin
				wf_r <= 1'b1;
				w_r  <= WDATA;
				ws_r <= WSTRB;
			end else if (wr_go) begin
				wf_r <= 1'b0;
			end
			if (wr_go) begin
				bv_r    <= 1'b1;
				bresp_r <= bad_w ? 2'h2 : 2'h0;
			end else if (BREADY) begin
				bv_r <= 1'b0;
			end
		end
	end
	always_comb begin
		bad_w = 1'b1;
		case (aw_r)
			PSDF_CTRL_OFS, PSDF_SPEED_OFS, PSDF_BLANK_OFS, PSDF_CYCLE_OFS,
			PSDF_KEY_OFS, PSDF_RADAR_OFS: bad_w = 1'b0;
			default: bad_w = !(aw_r[7:4] == PSDF_LABEL_OFS[7:4] && aw_r[1:0] == 2'h0);
		endcase
	end
	// Config registers; byte lanes honoured on stored fields
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			code_r    <= PSDF_CODE_RST;
			matrix_r  <= 1'b1;
			blank_t_r <= PSDF_BLANK_RST;
			cycle_t_r <= PSDF_CYCLE_RST;
			for (int i = 0; i < 4; i++) label_r[i] <= {4{PSDF_SPACE}};
		end else if (wr_go) begin
			if (aw_r == PSDF_CTRL_OFS && ws_r[0]) code_r <= wd[7:0];
			if (aw_r == PSDF_CTRL_OFS && ws_r[1]) matrix_r <= wd[8];
			if (aw_r == PSDF_BLANK_OFS && ws_r[0]) blank_t_r <= wd[7:0];
			if (aw_r == PSDF_CYCLE_OFS && ws_r[0]) cycle_t_r <= wd[7:0];
			if (aw_r[7:4] == PSDF_LABEL_OFS[7:4]) begin
				for (int b = 0; b < 4; b++)
					if (ws_r[b]) label_r[aw_r[3:2]][8*b+:8] <= wd[8*b+:8];
			end
		end
	end
	always_comb begin
		rd_val = 32'h0;
		case (ar_addr)
			PSDF_CTRL_OFS:   rd_val = {23'h0, matrix_r, code_r};
			PSDF_SPEED_OFS:  rd_val = {22'h0, mph_r};
			PSDF_BLANK_OFS:  rd_val = {24'h0, blank_t_r};
			PSDF_CYCLE_OFS:  rd_val = {24'h0, cycle_t_r};
			PSDF_STATUS_OFS: rd_val = {6'h0, kph, 3'h0, frame_r, 2'h0,
				alt_gun, auto_md, fr_r == FR_SEND, alt_r, metric_r, shown_r};
			default: begin
				if (ar_addr[7:4] == PSDF_LABEL_OFS[7:4]) rd_val = label_r[ar_addr[3:2]];
			end
		endcase
	end
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rv_r    <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= 2'h0;
		end else if (rd_go) begin
			rv_r    <= 1'b1;
			rdata_r <= rd_val;
			rresp_r <= (ar_addr[1:0] != 2'h0 || ar_addr > 8'h2c ||
				ar_addr == PSDF_KEY_OFS || ar_addr == PSDF_RADAR_OFS) ? 2'h2 : 2'h0;
		end else if (RREADY) begin
			rv_r <= 1'b0;
		end
	end
	// ==========================================================
	// Display state
	assign auto_md = code_r == PSDF_CODE_AUTO_A || code_r == PSDF_CODE_AUTO_B;
	assign alt_gun = code_r == PSDF_CODE_MAN_B || code_r == PSDF_CODE_AUTO_B;
	assign k_go    = wr_go && aw_r == PSDF_KEY_OFS;
	assign r_go    = wr_go && aw_r == PSDF_RADAR_OFS;
	assign kph_full = mph_r * PSDF_KPH_MUL;
	// 1.609 approximated as 412/256; clamp keeps three digits
	assign kph = (kph_full[18:8] > {1'b0, PSDF_SPEED_MAX}) ? PSDF_SPEED_MAX : kph_full[17:8];
	logic [3:0] kcmd;
	logic [4:0] kfr;
	assign kcmd = w_r[3:0];
	assign kfr  = w_r[12:8];
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			mph_r    <= 10'h0;
			frame_r  <= PSDF_FRAME_BLANK;
			shown_r  <= 1'b0;
			metric_r <= 1'b0;
			alt_r    <= 1'b0;
		end else if (blank_fire) begin
			mph_r   <= 10'h0;
			frame_r <= PSDF_FRAME_BLANK;
			shown_r <= 1'b0;
		end else if (k_go) begin
			case (kcmd)
				PSDF_KEY_PITCH: begin
					if (kfr != 5'h0 && kfr <= PSDF_FRAME_MAX && kfr != PSDF_FRAME_BLANK) begin
						frame_r <= kfr;
						shown_r <= 1'b1;
					end
				end
				PSDF_KEY_SPEED: begin
					frame_r <= PSDF_FRAME_BLANK;
					shown_r <= 1'b1;
				end
				PSDF_KEY_BLANK: begin
					mph_r   <= 10'h0;
					frame_r <= PSDF_FRAME_BLANK;
					shown_r <= 1'b0;
				end
				PSDF_KEY_FIX_IMP, PSDF_KEY_FIX_MET: begin
					alt_r    <= 1'b0;
					metric_r <= kcmd == PSDF_KEY_FIX_MET;
				end
				PSDF_KEY_ALT_IMP, PSDF_KEY_ALT_MET: begin
					alt_r    <= 1'b1;
					metric_r <= kcmd == PSDF_KEY_ALT_MET;
				end
				default: ;
			endcase
		end else begin
			// Unit toggle must not swallow a speed or radar write in the same cycle
			if (cyc_fire) metric_r <= !metric_r;
			if (wr_go && aw_r == PSDF_SPEED_OFS) begin
				mph_r <= (wd[9:0] > PSDF_SPEED_MAX) ? PSDF_SPEED_MAX : wd[9:0];
			end else if (r_go) begin
				mph_r <= (wd[9:0] > PSDF_SPEED_MAX) ? PSDF_SPEED_MAX : wd[9:0];
				if (auto_md) begin
					frame_r <= PSDF_FRAME_BLANK;
					shown_r <= 1'b1;
				end
			end
		end
	end
	// ==========================================================
	// Second timers; a new show restarts both
	logic [31:0] tick_r;
	logic [7:0]  bsec_r, csec_r;
	logic        sec;
	assign sec        = tick_r == 32'(SEC_CYC - 1);
	assign blank_fire = shown_r && blank_t_r != 8'h0 && sec && bsec_r == blank_t_r - 8'h1;
	assign cyc_fire   = shown_r && alt_r && cycle_t_r != 8'h0 && sec &&
		csec_r == cycle_t_r - 8'h1;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			tick_r <= 32'h0;
			bsec_r <= 8'h0;
			csec_r <= 8'h0;
		end else if (trig && !cyc_fire) begin
			tick_r <= 32'h0;
			bsec_r <= 8'h0;
			csec_r <= 8'h0;
		end else begin
			tick_r <= sec ? 32'h0 : tick_r + 32'h1;
			if (sec) bsec_r <= blank_fire ? 8'h0 : bsec_r + 8'h1;
			if (sec) csec_r <= cyc_fire ? 8'h0 : csec_r + 8'h1;
		end
	end
	// ==========================================================
	// Frame builder
	logic       start, push, f_rdy, f_ov, f_or, tx_go;
	logic [7:0] fbyte, f_od;
	assign trig = blank_fire || cyc_fire || (r_go && auto_md) ||
		(k_go && kcmd inside {PSDF_KEY_PITCH, PSDF_KEY_SPEED, PSDF_KEY_BLANK}) ||
		(k_go && shown_r && kcmd inside {PSDF_KEY_FIX_IMP, PSDF_KEY_FIX_MET,
			PSDF_KEY_ALT_IMP, PSDF_KEY_ALT_MET});
	assign start = fr_r == FR_IDLE && pend_r;
	assign push  = fr_r == FR_SEND && f_rdy;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) pend_r <= 1'b0;
		else       pend_r <= trig | (pend_r & !start); // Request set wins over clear
	end
	function automatic logic [7:0] dig(input logic [9:0] v, input logic [1:0] p);
		logic [3:0] h, t, u;
		h = 4'(v / 10'd100);
		t = 4'((v / 10'd10) % 10'd10);
		u = 4'(v % 10'd10);
		case (p)
			2'h0:    dig = (h == 4'h0) ? PSDF_SPACE : PSDF_ZERO + 8'(h);
			2'h1:    dig = (h == 4'h0 && t == 4'h0) ? PSDF_SPACE : PSDF_ZERO + 8'(t);
			default: dig = PSDF_ZERO + 8'(u);
		endcase
	endfunction
	logic [3:0] li;
	logic       show_imp, show_met;
	assign li       = 4'(idx_r - PSDF_LABEL_IDX);
	// Fixed-digit signs show only the selected unit
	assign show_imp = snap_r.shown && (snap_r.matrix || !snap_r.metric);
	assign show_met = snap_r.shown && (snap_r.matrix || snap_r.metric);
	always_comb begin
		fbyte = PSDF_SPACE;
		if (idx_r == 5'h0) fbyte = PSDF_STX;
		else if (idx_r == 5'h1) fbyte = {3'h0, snap_r.frame};
		else if (idx_r < PSDF_LABEL_IDX) begin
			if (show_imp) fbyte = dig(snap_r.mph, 2'(idx_r - 5'h2));
		end else if (idx_r < PSDF_KPH_IDX) begin
			if (snap_r.matrix && snap_r.frame != PSDF_FRAME_BLANK)
				fbyte = label_r[li[3:2]][8*li[1:0]+:8];
		end else if (idx_r < PSDF_LAST_IDX) begin
			if (show_met) fbyte = dig(snap_r.kph, 2'(idx_r - PSDF_KPH_IDX));
		end else fbyte = PSDF_ETX;
	end
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			fr_r   <= FR_IDLE;
			idx_r  <= 5'h0;
			snap_r <= '0;
		end else begin
			case (fr_r)
				FR_IDLE: if (start) begin
					fr_r   <= FR_SEND;
					idx_r  <= 5'h0;
					snap_r <= '{frame_r, mph_r, kph, shown_r, metric_r, matrix_r};
				end
				FR_SEND: if (push) begin
					idx_r <= idx_r + 5'h1;
					if (idx_r == PSDF_LAST_IDX) fr_r <= FR_IDLE;
				end
				default: fr_r <= FR_IDLE;
			endcase
		end
	end
	psdf_fifo #(.W(8), .D(PSDF_FIFO_DEP)) u_fifo (
		.clk       (CLK),
		.nrst      (NRST),
		.in_data   (fbyte),
		.in_valid  (fr_r == FR_SEND),
		.in_ready  (f_rdy),
		.out_data  (f_od),
		.out_valid (f_ov),
		.out_ready (f_or)
	);
	// ==========================================================
	// Serial sender, 8N1
	logic [9:0]  sh_r;
	logic [3:0]  bit_r;
	logic [31:0] bc_r;
	assign f_or  = tx_r == TX_IDLE;
	assign tx_go = f_ov && f_or;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			tx_r  <= TX_IDLE;
			sh_r  <= 10'h3ff;
			bit_r <= 4'h0;
			bc_r  <= 32'h0;
		end else begin
			case (tx_r)
				TX_IDLE: if (tx_go) begin
					tx_r  <= TX_BUSY;
					sh_r  <= {1'b1, f_od, 1'b0};
					bit_r <= 4'h0;
					bc_r  <= 32'h0;
				end
				TX_BUSY: begin
					if (bc_r == 32'(BIT_CYC - 1)) begin
						bc_r  <= 32'h0;
						sh_r  <= {1'b1, sh_r[9:1]};
						bit_r <= bit_r + 4'h1;
						if (bit_r == 4'h9) tx_r <= TX_IDLE;
					end else bc_r <= bc_r + 32'h1;
				end
				default: tx_r <= TX_IDLE;
			endcase
		end
	end
	assign TXD = sh_r[0];
	// ==========================================================
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	chk_request_held: assert property (trig && !start && fr_r == FR_IDLE |=> start)
		else $error("frame request lost");
	chk_blank_clears: assert property (k_go && kcmd == PSDF_KEY_BLANK && !blank_fire
		|=> mph_r == 10'h0 && !shown_r && frame_r == PSDF_FRAME_BLANK)
		else $error("blank key left speed");
	chk_speed_only: assert property (k_go && kcmd == PSDF_KEY_SPEED && !blank_fire
		|=> frame_r == PSDF_FRAME_BLANK && shown_r && pend_r)
		else $error("speed key frame wrong");
	chk_fix_metric: assert property (k_go && kcmd == PSDF_KEY_FIX_MET && !blank_fire
		|=> metric_r && !alt_r)
		else $error("fix metric failed");
	chk_alt_order: assert property (k_go && kcmd == PSDF_KEY_ALT_IMP && !blank_fire
		|=> alt_r && !metric_r)
		else $error("alternation order wrong");
	chk_zero_timeout: assert property (blank_t_r == 8'h0 && shown_r && !k_go |=> shown_r)
		else $error("blanking with zero timeout");
	chk_auto_radar: assert property (r_go && auto_md && !blank_fire && !k_go
		|=> shown_r && pend_r)
		else $error("radar speed not sent");
	chk_frame_head: assert property (push && idx_r == 5'h0 |-> fbyte == PSDF_STX
		##1 (idx_r == 5'h1))
		else $error("frame header wrong");
	chk_start_bit: assert property (tx_go |=> !TXD [*2])
		else $error("start bit missing");
	chk_idle_line: assert property (tx_r == TX_IDLE |-> TXD)
		else $error("line not idle high");
	cov_pitch: cover property (k_go && kcmd == PSDF_KEY_PITCH ##1 start);
	cov_blank_time: cover property (blank_fire);
	cov_unit_cycle: cover property (cyc_fire);
	cov_fifo_full: cover property (fr_r == FR_SEND && !f_rdy);
endmodule

// >>> tb/psdf_display_model.sv
// Behavioural display controller: receives the formatter's serial bytes.
// Assumes TXD idles high and the bit period equals the formatter's BIT_CYC.
`timescale 1ns/1ns
module psdf_display_model #(
	parameter int BIT_CYC = 8
) (
	input  wire logic       clk,
	input  wire logic       txd,
	output      logic [8:0] rx_word,
	output      logic       rx_stb
);
	logic [8:0] sh;

	// ==========================================================
	// Receiver
	// Start bit checked mid-bit; stop bit kept in word bit 8
	// One process owns both outputs, so each has a single driver
	initial begin
		rx_word = 9'h000;
		rx_stb  = 1'b0;
		forever begin
			@(negedge txd);
			repeat (BIT_CYC / 2) @(posedge clk);
			if (txd === 1'b0) begin
				for (int i = 0; i < 9; i++) begin
					repeat (BIT_CYC) @(posedge clk);
					sh[i] = txd;
				end
				rx_word <= sh;
				rx_stb  <= 1'b1;
				@(posedge clk);
				rx_stb <= 1'b0;
			end
		end
	end
endmodule

// >>> tb/psdf_formatter_tb_top.sv
// Self-checking bench of the pitch speed formatter.
// Assumes short BIT_CYC and SEC_CYC values so that frames and seconds run quickly.
`timescale 1ns/1ns
module psdf_formatter_tb_top import psdf_pkg::*;;
	localparam int BC = 8;
	localparam int SC = 4000;
	logic        CLK, NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, TXD, rx_stb;
	logic [7:0]  AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, lfsr;
	logic [1:0]  BRESP, RRESP;
	logic [8:0]  rx_word;
	logic [4:0]  fr;
	logic [34:0] re;
	logic [7:0]  lbl [16];
	logic [8:0]  txq [$];
	logic [1:0]  bq [$];
	logic [34:0] rq [$];
	int          fails, checks_done, mph;

	always #2 CLK = ~CLK;

	psdf_formatter #(.BIT_CYC(BC), .SEC_CYC(SC)) i_psdf_formatter (
		.CLK(CLK), .NRST(NRST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY), .TXD(TXD));

	psdf_display_model #(.BIT_CYC(BC)) i_psdf_display_model (
		.clk(CLK), .txd(TXD), .rx_word(rx_word), .rx_stb(rx_stb));

	// ==========================================================
	// Checking and closing
	task automatic chk(input logic [34:0] g, input logic [34:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic close_out;
		$display("Checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Oldest note is compared whenever a result appears; stray bytes never match
	always @(posedge CLK) begin
		if (rx_stb)
			chk({26'h0, rx_word}, txq.size() > 0 ? {26'h0, txq.pop_front()} : '1);
		if (BVALID && BREADY)
			chk({33'h0, BRESP}, {33'h0, bq.pop_front()});
		if (RVALID && RREADY) begin
			re = rq.pop_front();
			chk({1'b0, RRESP, re[34] ? RDATA : 32'h0}, {1'b0, re[33:0]});
		end
	end

	// ==========================================================
	// Bus master and expectations
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ad;
		logic dd;
		bq.push_back(r);
		AWADDR  <= a;
		WDATA   <= d;
		AWVALID <= 1'b1;
		WVALID  <= 1'b1;
		ad = 1'b0;
		dd = 1'b0;
		while (!(ad && dd)) begin
			@(posedge CLK);
			if (!ad && AWREADY) begin
				ad = 1'b1;
				AWVALID <= 1'b0;
			end
			if (!dd && WREADY) begin
				dd = 1'b1;
				WVALID <= 1'b0;
			end
		end
		BREADY <= 1'b1;
		do @(posedge CLK); while (!BVALID);
		BREADY <= 1'b0;
	endtask

	// e holds {compare data, response, data}
	task automatic axr(input logic [7:0] a, input logic [34:0] e);
		rq.push_back(e);
		ARADDR  <= a;
		ARVALID <= 1'b1;
		do @(posedge CLK); while (!ARREADY);
		ARVALID <= 1'b0;
		RREADY  <= 1'b1;
		do @(posedge CLK); while (!RVALID);
		RREADY <= 1'b0;
	endtask

	task automatic key(input logic [3:0] k, input logic [4:0] f);
		axw(PSDF_KEY_OFS, {19'h0, f, 4'h0, k}, 2'b00);
	endtask

	function automatic logic [7:0] dg(input int v, input int p);
		int pw;
		pw = (p == 2) ? 100 : (p == 1) ? 10 : 1;
		if (p > 0 && v < pw)
			return PSDF_SPACE;
		return PSDF_ZERO + 8'((v / pw) % 10);
	endfunction

	// Notes one whole frame: start, frame number, 22 items, end
	task automatic expf(input logic [4:0] f, input int m, input logic sh, mx, met);
		int k;
		logic [7:0] b [25];
		k = (m * 412) >> 8;
		if (k > 999)
			k = 999;
		b[0]  = PSDF_STX;
		b[1]  = {3'h0, f};
		b[24] = PSDF_ETX;
		for (int i = 0; i < 3; i++) begin
			b[2+i]  = (sh && (mx || !met)) ? dg(m, 2 - i) : PSDF_SPACE;
			b[21+i] = (sh && (mx || met)) ? dg(k, 2 - i) : PSDF_SPACE;
		end
		for (int i = 0; i < 16; i++)
			b[5+i] = (mx && f != PSDF_FRAME_BLANK) ? lbl[i] : PSDF_SPACE;
		foreach (b[i])
			txq.push_back({1'b1, b[i]});
	endtask

	task automatic drain;
		while (txq.size() > 0)
			@(posedge CLK);
		repeat (4 * BC) @(posedge CLK);
	endtask

	function automatic logic [31:0] nx(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
	endfunction

	// ==========================================================
	// Scenarios
	initial begin
		CLK = 1'b0;
		NRST = 1'b0;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
		AWADDR = 8'h00;
		ARADDR = 8'h00;
		WDATA = 32'h0;
		lfsr = 32'hbdfb;
		fails = 0;
		checks_done = 0;
		for (int k = 0; k < 16; k++)
			lbl[k] = 8'h41 + 8'(k);
		repeat (16) @(posedge CLK);
		NRST <= 1'b1;
		@(posedge CLK);
		axr(PSDF_CTRL_OFS, {3'h4, 32'h0000_01bf});
		axr(PSDF_BLANK_OFS, {3'h4, 32'h0});
		axr(PSDF_CYCLE_OFS, {3'h4, 32'h0000_0002});
		axr(8'h40, {3'h2, 32'h0});
		axr(PSDF_KEY_OFS, {3'h2, 32'h0});
		axw(8'h40, 32'h0, 2'b10);
		axw(PSDF_STATUS_OFS, 32'h0, 2'b10);
		axw(PSDF_SPEED_OFS, 32'h0000_03f0, 2'b00);
		axr(PSDF_SPEED_OFS, {3'h4, 32'h0000_03e7});
		for (int w = 0; w < 4; w++)
			axw(PSDF_LABEL_OFS + 8'(4 * w), {lbl[4*w+3], lbl[4*w+2], lbl[4*w+1], lbl[4*w]}, 2'b00);
		// Every sport code: manual codes by pitch key, automatic ones by radar
		for (int c = 0; c < 4; c++) begin
			lfsr = nx(lfsr);
			mph = int'(lfsr % 1000);
			fr = 5'(lfsr[15:8] % 18 + 1);
			if (fr == PSDF_FRAME_BLANK)
				fr = 5'h0b;
			axw(PSDF_CTRL_OFS, 32'h0000_01bf + 32'(c), 2'b00);
			if (c % 2 == 0) begin
				axw(PSDF_SPEED_OFS, 32'(mph), 2'b00);
				expf(fr, mph, 1'b1, 1'b1, 1'b0);
				key(PSDF_KEY_PITCH, fr);
			end else begin
				expf(PSDF_FRAME_BLANK, mph, 1'b1, 1'b1, 1'b0);
				axw(PSDF_RADAR_OFS, 32'(mph), 2'b00);
			end
			drain();
		end
		axw(PSDF_CTRL_OFS, 32'h0000_01bf, 2'b00);
		axw(PSDF_SPEED_OFS, 32'(mph), 2'b00);
		expf(PSDF_FRAME_BLANK, mph, 1'b1, 1'b1, 1'b0);
		key(PSDF_KEY_SPEED, 5'h00);
		drain();
		expf(PSDF_FRAME_BLANK, 0, 1'b0, 1'b1, 1'b0);
		key(PSDF_KEY_BLANK, 5'h00);
		drain();
		// Fixed-digit display: one unit at a time
		axw(PSDF_CTRL_OFS, 32'h0000_00bf, 2'b00);
		axw(PSDF_SPEED_OFS, 32'(mph), 2'b00);
		expf(PSDF_FRAME_BLANK, mph, 1'b1, 1'b0, 1'b0);
		key(PSDF_KEY_SPEED, 5'h00);
		drain();
		for (int a = 0; a < 2; a++) begin
			expf(PSDF_FRAME_BLANK, mph, 1'b1, 1'b0, a[0]);
			expf(PSDF_FRAME_BLANK, mph, 1'b1, 1'b0, !a[0]);
			key(a[0] ? PSDF_KEY_ALT_MET : PSDF_KEY_ALT_IMP, 5'h00);
			drain();
			expf(PSDF_FRAME_BLANK, mph, 1'b1, 1'b0, a[0]);
			key(a[0] ? PSDF_KEY_FIX_MET : PSDF_KEY_FIX_IMP, 5'h00);
			drain();
			// Alternation must have stopped: no frame at the next period
			repeat (2 * SC + 1000) @(posedge CLK);
		end
		// Blank timeout of one second, then zero disables it
		axw(PSDF_CTRL_OFS, 32'h0000_01bf, 2'b00);
		expf(fr, mph, 1'b1, 1'b1, 1'b0);
		key(PSDF_KEY_PITCH, fr);
		axw(PSDF_BLANK_OFS, 32'h0000_0001, 2'b00);
		expf(PSDF_FRAME_BLANK, 0, 1'b0, 1'b1, 1'b0);
		drain();
		axw(PSDF_BLANK_OFS, 32'h0, 2'b00);
		expf(fr, 0, 1'b1, 1'b1, 1'b0);
		key(PSDF_KEY_PITCH, fr);
		drain();
		repeat (2 * SC + 1000) @(posedge CLK);
		close_out();
	end

	initial begin
		repeat (90000) @(posedge CLK);
		fails++;
		close_out();
	end
endmodule
